// ### src/ccim_ctrl.sv
// Functional notes
// - carry set: wrap flag set, nibble and subtract cleared, others kept
// - carry set is opcode 37, one machine cycle of four states
// - opcode 76 halts until interrupt or reset, four states
// - while halted, idle machine cycles repeat like the idle op
// - F3 clears both enable latches in four states, no flags touched
// - disable takes effect during its own execution
// - after disable the request is ignored until unmask sets latches
// - with latches clear no request is answered
// - FB sets both latches, four states, flags untouched
// - unmask and the next instruction are never interrupted
// - ED 46 selects mode zero in two machine cycles
// - mode zero runs the instruction the peripheral puts on the bus
// - mode zero first byte in acknowledge, rest by normal reads
// - ED 56 selects mode one in two machine cycles
// - mode one calls 0038 and ignores the data bus
// - ED 5E selects mode two in two machine cycles
// - mode two pointer is vector page high, vector low
// - mode two reads routine address from table, then calls it
// - enable and disable leave every flag unchanged
//
// Register access over APB and the register addresses are this design's own decisions.
module ccim_ctrl
  import ccim_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        op_valid,
  input  wire logic [7:0]  op_byte,
  output logic             op_ready,
  input  wire logic        irq_n,
  input  wire logic [7:0]  data_bus_in,
  output logic             int_ack,
  output logic             halted,
  output logic             inject_valid,
  output logic      [7:0]  inject_byte,
  output logic             call_valid,
  output logic      [15:0] call_addr,
  output logic             mem_rd_req,
  output logic      [15:0] mem_rd_addr,
  input  wire logic        mem_rd_ack,
  input  wire logic [7:0]  mem_rd_data
);

  typedef struct packed {
    ccim_state_e state;
    logic [3:0]  clk_cnt;
    logic [1:0]  m_left;
    logic        latch_a;
    logic        latch_b;
    logic [1:0]  hold;
    ccim_mode_e  mode;
    logic [7:0]  flags;
    logic [7:0]  vpage;
    logic [15:0] ack_cnt;
    logic        irq_s1;
    logic        irq_s2;
    logic [7:0]  bus_s1;
    logic [7:0]  bus_s2;
    logic [15:0] ptr;
    logic [7:0]  tbl_lo;
    logic        int_ack;
    logic        inject_valid;
    logic [7:0]  inject_byte;
    logic        call_valid;
    logic [15:0] call_addr;
    logic        mem_rd_req;
    logic [31:0] prdata;
    logic        pslverr;
  } ccim_s;

  ccim_s st_r;
  ccim_s st_nxt;

  logic        setup_ph;
  logic        acc_ph;
  logic        mcyc_end;
  logic        irq_take;
  logic        hw_flag;
  logic [7:0]  flag_val;
  logic [31:0] rd_val;
  logic        rd_hit;

  assign setup_ph = psel & ~penable;
  assign acc_ph   = psel & penable;
  assign mcyc_end = (st_r.clk_cnt == CCIM_MCYC_CLKS - 4'h1);
  // only latch a gates acceptance; the hold covers unmask and its follower
  assign irq_take = st_r.latch_a & ~st_r.irq_s2 &
                    (st_r.hold == 2'h0);

  always_comb begin
    rd_hit = 1'b1;
    unique case (paddr)
      CCIM_OFF_STATUS: begin
        rd_val = '0;
        rd_val[CCIM_ST_LATCH_A]            = st_r.latch_a;
        rd_val[CCIM_ST_LATCH_B]            = st_r.latch_b;
        rd_val[CCIM_ST_MODE_LO +: 2]       = st_r.mode;
        rd_val[CCIM_ST_HALTED]             = (st_r.state == CCIM_HALT);
        rd_val[CCIM_ST_HOLD]               = (st_r.hold != 2'h0);
      end
      CCIM_OFF_FLAGS:  rd_val = {24'h000000, st_r.flags};
      CCIM_OFF_VPAGE:  rd_val = {24'h000000, st_r.vpage};
      CCIM_OFF_ACKCNT: rd_val = {16'h0000, st_r.ack_cnt};
      default: begin
        rd_val = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    op_ready = 1'b0;
    hw_flag  = 1'b0;
    flag_val = st_r.flags;

    // request pin passes two flops before anything looks at it
    st_nxt.irq_s1 = irq_n;
    st_nxt.irq_s2 = st_r.irq_s1;
    st_nxt.bus_s1 = data_bus_in;
    st_nxt.bus_s2 = st_r.bus_s1;

    st_nxt.inject_valid = 1'b0;
    st_nxt.call_valid   = 1'b0;
    st_nxt.clk_cnt      = mcyc_end ? 4'h0 : st_r.clk_cnt + 4'h1;

    // apb: answer is prepared in the setup cycle, zero wait states
    if (setup_ph) begin
      st_nxt.prdata  = pwrite ? 32'h00000000 : rd_val;
      st_nxt.pslverr = ~rd_hit | (pwrite & (paddr == CCIM_OFF_STATUS));
    end

    unique case (st_r.state)
      CCIM_IDLE: begin
        st_nxt.clk_cnt = 4'h0;
        if (irq_take) begin
          st_nxt.state   = CCIM_ACK;
          st_nxt.int_ack = 1'b1;
          st_nxt.latch_a = 1'b0;
          st_nxt.latch_b = 1'b0;
        end else if (op_valid) begin
          op_ready      = 1'b1;
          st_nxt.state  = CCIM_EXEC;
          st_nxt.m_left = 2'h0;
          st_nxt.clk_cnt = 4'h1;
          if (st_r.hold != 2'h0) begin
            st_nxt.hold = st_r.hold - 2'h1;
          end
          unique case (op_byte)
            CCIM_OP_CARRY_SET: begin
              hw_flag  = 1'b1;
              flag_val[CCIM_FLG_WRAP]   = 1'b1;
              flag_val[CCIM_FLG_NIBBLE] = 1'b0;
              flag_val[CCIM_FLG_SUB]    = 1'b0;
            end
            CCIM_OP_HALT: begin
              st_nxt.state = CCIM_HALT;
            end
            CCIM_OP_MASK_OFF: begin
              // cleared at decode so its own boundary is already shut
              st_nxt.latch_a = 1'b0;
              st_nxt.latch_b = 1'b0;
            end
            CCIM_OP_UNMASK: begin
              st_nxt.latch_a = 1'b1;
              st_nxt.latch_b = 1'b1;
              st_nxt.hold    = CCIM_UNMASK_HOLD;
            end
            CCIM_OP_PREFIX: begin
              st_nxt.state = CCIM_PREFIX;
            end
            default: ;
          endcase
        end
      end
      CCIM_EXEC: begin
        if (mcyc_end) begin
          if (st_r.m_left == 2'h0) begin
            st_nxt.state = CCIM_IDLE;
          end else begin
            st_nxt.m_left = st_r.m_left - 2'h1;
          end
        end
      end
      CCIM_PREFIX: begin
        // second byte is taken once the first machine cycle is over
        if (st_r.clk_cnt == 4'h0) begin
          st_nxt.clk_cnt = 4'h0;
          if (op_valid) begin
            op_ready       = 1'b1;
            st_nxt.state   = CCIM_EXEC;
            st_nxt.clk_cnt = 4'h1;
            unique case (op_byte)
              CCIM_OP_MODE_ZERO: st_nxt.mode = CCIM_MODE_FIXED;
              CCIM_OP_MODE_ONE:  st_nxt.mode = CCIM_MODE_RESTART;
              CCIM_OP_MODE_TWO:  st_nxt.mode = CCIM_MODE_VECTOR;
              default: ;
            endcase
          end
        end
      end
      CCIM_HALT: begin
        // idle machine cycles; the request is looked at only at their ends
        if (mcyc_end && irq_take) begin
          st_nxt.state   = CCIM_ACK;
          st_nxt.int_ack = 1'b1;
          st_nxt.latch_a = 1'b0;
          st_nxt.latch_b = 1'b0;
        end
      end
      CCIM_ACK: begin
        if (mcyc_end) begin
          st_nxt.int_ack = 1'b0;
          st_nxt.ack_cnt = st_r.ack_cnt + 16'h0001;
          unique case (st_r.mode)
            CCIM_MODE_FIXED: begin
              // decoder fetches further bytes by normal reads
              st_nxt.inject_valid = 1'b1;
              st_nxt.inject_byte  = st_r.bus_s2;
              st_nxt.state        = CCIM_IDLE;
            end
            CCIM_MODE_RESTART: begin
              st_nxt.call_valid = 1'b1;
              st_nxt.call_addr  = CCIM_RESTART_ADDR;
              st_nxt.state      = CCIM_IDLE;
            end
            CCIM_MODE_VECTOR: begin
              st_nxt.ptr        = {st_r.vpage, st_r.bus_s2};
              st_nxt.mem_rd_req = 1'b1;
              st_nxt.state      = CCIM_TBL_LO;
            end
            default: st_nxt.state = CCIM_IDLE;
          endcase
        end
      end
      CCIM_TBL_LO: begin
        if (mem_rd_ack) begin
          st_nxt.tbl_lo = mem_rd_data;
          st_nxt.ptr    = st_r.ptr + 16'h0001;
          st_nxt.state  = CCIM_TBL_HI;
        end
      end
      CCIM_TBL_HI: begin
        if (mem_rd_ack) begin
          st_nxt.mem_rd_req = 1'b0;
          st_nxt.call_valid = 1'b1;
          st_nxt.call_addr  = {mem_rd_data, st_r.tbl_lo};
          st_nxt.state      = CCIM_IDLE;
        end
      end
      default: st_nxt.state = CCIM_IDLE;
    endcase

    // a flag change by an instruction wins over a software write
    if (acc_ph && pwrite && paddr == CCIM_OFF_FLAGS && !hw_flag) begin
      st_nxt.flags = pwdata[7:0];
    end else begin
      st_nxt.flags = flag_val;
    end
    if (acc_ph && pwrite && paddr == CCIM_OFF_VPAGE) begin
      st_nxt.vpage = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r              <= '0;
      st_r.state        <= CCIM_IDLE;
      st_r.mode         <= CCIM_MODE_FIXED;
      st_r.flags        <= CCIM_FLAGS_RST;
      st_r.vpage        <= CCIM_VPAGE_RST;
      st_r.irq_s1       <= 1'b1;
      st_r.irq_s2       <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata       = st_r.prdata;
  assign pready       = 1'b1;
  assign pslverr      = st_r.pslverr & acc_ph;
  assign int_ack      = st_r.int_ack;
  assign halted       = (st_r.state == CCIM_HALT);
  assign inject_valid = st_r.inject_valid;
  assign inject_byte  = st_r.inject_byte;
  assign call_valid   = st_r.call_valid;
  assign call_addr    = st_r.call_addr;
  assign mem_rd_req   = st_r.mem_rd_req;
  assign mem_rd_addr  = st_r.ptr;

endmodule

// ### src/ccim_pkg.sv
package ccim_pkg;

  // apb register byte offsets
  localparam logic [11:0] CCIM_OFF_STATUS = 12'h000;
  localparam logic [11:0] CCIM_OFF_FLAGS  = 12'h004;
  localparam logic [11:0] CCIM_OFF_VPAGE  = 12'h008;
  localparam logic [11:0] CCIM_OFF_ACKCNT = 12'h00C;

  // condition flag bit positions in the flag byte
  localparam int CCIM_FLG_TOP    = 7;
  localparam int CCIM_FLG_NULL   = 6;
  localparam int CCIM_FLG_NIBBLE = 4;
  localparam int CCIM_FLG_PAROV  = 2;
  localparam int CCIM_FLG_SUB    = 1;
  localparam int CCIM_FLG_WRAP   = 0;

  // status register field positions
  localparam int CCIM_ST_LATCH_A = 0;
  localparam int CCIM_ST_LATCH_B = 1;
  localparam int CCIM_ST_MODE_LO = 2;
  localparam int CCIM_ST_HALTED  = 4;
  localparam int CCIM_ST_HOLD    = 5;

  // reset values
  localparam logic [7:0] CCIM_FLAGS_RST = 8'h00;
  localparam logic [7:0] CCIM_VPAGE_RST = 8'h00;

  // opcodes
  localparam logic [7:0] CCIM_OP_CARRY_SET = 8'h37;
  localparam logic [7:0] CCIM_OP_HALT      = 8'h76;
  localparam logic [7:0] CCIM_OP_MASK_OFF  = 8'hF3;
  localparam logic [7:0] CCIM_OP_UNMASK    = 8'hFB;
  localparam logic [7:0] CCIM_OP_PREFIX    = 8'hED;
  localparam logic [7:0] CCIM_OP_MODE_ZERO = 8'h46;
  localparam logic [7:0] CCIM_OP_MODE_ONE  = 8'h56;
  localparam logic [7:0] CCIM_OP_MODE_TWO  = 8'h5E;

  localparam logic [15:0] CCIM_RESTART_ADDR = 16'h0038;

  // timing: one clock state is one pclk cycle of 25 ns
  localparam int CCIM_CLK_NS        = 25;
  localparam int CCIM_TSTATE_NS     = 25;
  localparam int CCIM_TSTATE_CYC    = (CCIM_TSTATE_NS + CCIM_CLK_NS - 1)
                                      / CCIM_CLK_NS;
  localparam int CCIM_TSTATES_PER_M = 4;
  localparam logic [3:0] CCIM_MCYC_CLKS =
    4'(CCIM_TSTATES_PER_M * CCIM_TSTATE_CYC);
  // one count: the op after unmask clears it at its take, so that op's
  // own end is the first boundary that may accept
  localparam logic [1:0] CCIM_UNMASK_HOLD = 2'h1;

  typedef enum logic [1:0] {
    CCIM_MODE_FIXED,
    CCIM_MODE_RESTART,
    CCIM_MODE_VECTOR
  } ccim_mode_e;

  typedef enum logic [2:0] {
    CCIM_IDLE,
    CCIM_EXEC,
    CCIM_PREFIX,
    CCIM_HALT,
    CCIM_ACK,
    CCIM_TBL_LO,
    CCIM_TBL_HI
  } ccim_state_e;

endpackage

// ### dv/ccim_chk.sv
module ccim_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        op_ready,
  input wire logic        int_ack,
  input wire logic        halted,
  input wire logic        inject_valid,
  input wire logic        call_valid,
  input wire logic [15:0] call_addr,
  input wire logic        mem_rd_req,
  input wire logic [15:0] mem_rd_addr,
  input wire logic        mem_rd_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ack_len: assert property (
    $rose(int_ack) |-> int_ack[*4] ##1 !int_ack) else $error("ack len");
  a_ack_no_take: assert property (
    $rose(int_ack) |-> !$past(op_ready)) else $error("op taken at accept");
  a_take_idle: assert property (
    op_ready |-> !halted && !int_ack) else $error("op taken off boundary");
  a_halt_exit: assert property (
    $fell(halted) |-> int_ack || $past(int_ack)) else $error("halt exit");
  a_inject_end: assert property (
    inject_valid |-> $fell(int_ack)) else $error("inject timing");
  a_fixed_addr: assert property (
    call_valid && $fell(int_ack) |-> call_addr == 16'h0038)
    else $error("restart addr");
  a_tbl_step: assert property (
    $rose(mem_rd_req) |-> ##[0:20] mem_rd_ack ##1
      mem_rd_addr == $past(mem_rd_addr) + 16'h0001) else $error("tbl step");
  a_call_tbl: assert property (
    mem_rd_req ##1 !mem_rd_req |-> call_valid) else $error("tbl call");
  c_inject: cover property (inject_valid);
  c_table: cover property (mem_rd_ack);
  c_halt: cover property ($fell(halted));
endmodule

bind ccim_ctrl ccim_chk u_chk (.pclk(pclk), .presetn(presetn),
  .op_ready(op_ready), .int_ack(int_ack), .halted(halted),
  .inject_valid(inject_valid), .call_valid(call_valid),
  .call_addr(call_addr), .mem_rd_req(mem_rd_req),
  .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack));

// ### dv/ccim_periph.sv
module ccim_periph (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        raise,
  input  wire logic [7:0]  vec,
  input  wire logic        int_ack,
  input  wire logic        mem_rd_req,
  input  wire logic [15:0] mem_rd_addr,
  output logic             irq_n,
  output logic      [7:0]  data_bus_in,
  output logic             mem_rd_ack,
  output logic      [7:0]  mem_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       pend_r;
  logic [7:0] word;
  // request held until acknowledged
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {pend_r, mem_rd_ack} <= 2'b00;
    else {pend_r, mem_rd_ack} <= {(pend_r | raise) & ~int_ack,
                                  mem_rd_req & ~mem_rd_ack};
  assign irq_n = ~pend_r;
  assign word = mem_rd_addr[15:8] ^ mem_rd_addr[7:0] ^ 8'hA5;
  // inverted outside ack so stale values never match
  assign data_bus_in = int_ack ? vec : ~vec;
  assign mem_rd_data = mem_rd_ack ? word : ~word;
endmodule

// ### dv/ccim_ctrl_tb.sv
module ccim_ctrl_tb
  import ccim_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, err, raise;
  logic        op_valid, op_ready, irq_n, int_ack, halted, inject_valid;
  logic        call_valid, mem_rd_req, mem_rd_ack;
  logic [7:0]  op_byte, data_bus_in, inject_byte, mem_rd_data, vp, vec, fx;
  logic [7:0]  mb [3] = '{8'h46, 8'h56, 8'h5E};
  logic [11:0] paddr;
  logic [15:0] call_addr, mem_rd_addr;
  logic [31:0] pwdata, prdata, rd;
  int          fails = 0, compares = 0, acks = 0, seed = 6218, n, m;

  ccim_ctrl u_ccim_ctrl (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .op_valid     (op_valid),
    .op_byte      (op_byte),
    .op_ready     (op_ready),
    .irq_n        (irq_n),
    .data_bus_in  (data_bus_in),
    .int_ack      (int_ack),
    .halted       (halted),
    .inject_valid (inject_valid),
    .inject_byte  (inject_byte),
    .call_valid   (call_valid),
    .call_addr    (call_addr),
    .mem_rd_req   (mem_rd_req),
    .mem_rd_addr  (mem_rd_addr),
    .mem_rd_ack   (mem_rd_ack),
    .mem_rd_data  (mem_rd_data)
  );
  ccim_periph u_ccim_periph (
    .pclk        (pclk),
    .presetn     (presetn),
    .raise       (raise),
    .vec         (vec),
    .int_ack     (int_ack),
    .mem_rd_req  (mem_rd_req),
    .mem_rd_addr (mem_rd_addr),
    .irq_n       (irq_n),
    .data_bus_in (data_bus_in),
    .mem_rd_ack  (mem_rd_ack),
    .mem_rd_data (mem_rd_data)
  );
  initial forever #12.5 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) fails++;
    if (got !== exp) $display("BAD %0t got %h exp %h", $time, got, exp);
  endtask
  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // bounded wait, sampled mid-cycle where outputs are settled
  task automatic await(ref logic s);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (s !== 1'b1 && n < 50);
    if (s !== 1'b1) fails++;
    if (s !== 1'b1) results();
  endtask
  function automatic logic [7:0] tbl(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'hA5;
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    await(pready);
    @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic [7:0] b);
    @(posedge pclk);
    op_valid <= 1'b1;
    op_byte <= b;
    await(op_ready);
    @(posedge pclk);
    op_valid <= 1'b0;
  endtask
  task automatic resp(input int m);
    logic [15:0] p;
    p = {vp, vec};
    if (m == 0) await(inject_valid);
    else await(call_valid);
    if (m == 0)
      chk({inject_valid, inject_byte}, {1'b1, vec});
    else if (m == 1)
      chk({call_valid, call_addr}, 17'h10038);
    else
      chk({call_valid, call_addr},
          {1'b1, tbl(p + 16'h0001), tbl(p)});
    // back on a rising edge so the next stimulus is launched there
    @(posedge pclk);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, op_valid, raise} = '0;
    {paddr, pwdata, op_byte, vp, vec} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CCIM_OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    fx = 8'($random(seed));
    apb(1'b1, CCIM_OFF_FLAGS, {24'h0, fx});
    op(8'h37);
    apb(1'b0, CCIM_OFF_FLAGS, 32'h0);
    fx = (fx | 8'h01) & 8'hED;
    chk(rd, {24'h0, fx});
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    // each mode; request raised before unmask to probe the delay
    // order one, zero, two: mode zero is the reset mode, so mode one goes first
    for (int i = 0; i < 3; i++) begin
      m = (4 - i) % 3;
      vp = 8'($random(seed));
      vec <= 8'($random(seed));
      apb(1'b1, CCIM_OFF_VPAGE, {24'h0, vp});
      op(8'hED);
      op(mb[m]);
      raise <= 1'b1;
      op(8'hFB);
      raise <= 1'b0;
      op(8'h00);
      apb(1'b0, CCIM_OFF_ACKCNT, 32'h0);
      chk(rd, acks);
      resp(m);
      acks++;
    end
    op(8'hFB);
    op(8'hF3);
    raise <= 1'b1;
    op(8'h00);
    raise <= 1'b0;
    repeat (12) @(posedge pclk);
    apb(1'b0, CCIM_OFF_STATUS, 32'h0);
    chk(rd, 32'h8);
    apb(1'b0, CCIM_OFF_ACKCNT, 32'h0);
    chk(rd, acks);
    apb(1'b0, CCIM_OFF_FLAGS, 32'h0);
    chk(rd, {24'h0, fx});
    op(8'hFB);
    op(8'h76);
    @(negedge pclk);
    chk({31'h0, halted}, 32'h1);
    resp(2);
    chk({31'h0, halted}, 32'h0);
    results();
  end
endmodule
